// file: adcp_defs.vh
// Constants and field positions of the converter serial configuration port.
`ifndef ADCP_DEFS_VH
`define ADCP_DEFS_VH

// ****************************************************************
// Configuration word fields, first received bit at the top.
// ****************************************************************
`define ADCP_CFG_BITS       8
`define ADCP_F_SINGLE       7
`define ADCP_F_ODD          6
`define ADCP_F_SEL_HI       5
`define ADCP_F_SEL_LO       4
`define ADCP_F_SPAN         3
`define ADCP_F_ORDER        2
`define ADCP_F_WL_HI        1
`define ADCP_F_WL_LO        0

// ****************************************************************
// Word lengths and codes.
// ****************************************************************
`define ADCP_WL_8           2'h0
`define ADCP_WL_DOWN        2'h1
`define ADCP_WL_12          2'h2
`define ADCP_WL_16          2'h3
`define ADCP_LEN_8          5'h08
`define ADCP_LEN_10         5'h0a
`define ADCP_LEN_12         5'h0c
`define ADCP_LEN_16         5'h10
`define ADCP_RES_BITS       12
`define ADCP_BIPOLAR_FLIP   12'h800
`define ADCP_RESULT_RST     12'h000
`define ADCP_CFG_RST        8'h00

// ****************************************************************
// Timing in conversion-clock falling edges.
// ****************************************************************
`define ADCP_DEGLITCH_EDGES 2'h2
`define ADCP_CONV_EDGES     4'hc

`endif

// file: adcp_host.sv
// Serial port master model driving select, shift clock and data input.
`timescale 1ns/1ps
`default_nettype none
module adcp_host (
	input  wire logic mclk,
	input  wire logic dout,
	input  wire logic dout_oe,
	input  wire logic conv_busy,
	output var  logic cs_n_pin,
	output var  logic sclk_pin,
	output var  logic din_pin
);
	initial begin
		cs_n_pin = 1'h1;
		sclk_pin = 1'h0;
		din_pin = 1'h0;
	end
	// ****
	// One exchange; a bit taken while the output floats is marked unknown.
	// ****
	task automatic xfer(input logic [7:0] cfg, output logic [15:0] got, input logic hold);
		logic [4:0] len;
		int         n;
		len = cfg[1] ? (cfg[0] ? 5'h10 : 5'h0c) : (cfg[0] ? 5'h0a : 5'h08);
		got = 16'h0000;
		n = 0;
		@(posedge mclk) cs_n_pin <= 1'h0;
		while (dout_oe !== 1'h1 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		for (int i = 0; i < len; i++) begin
			@(posedge mclk) sclk_pin <= 1'h0;
			din_pin <= (i < 8) ? cfg[7 - i] : 1'h1;
			repeat (4) @(posedge mclk);
			sclk_pin <= 1'h1;
			@(negedge mclk) got[i] = dout_oe ? dout : 1'hx;
			repeat (3) @(posedge mclk);
		end
		@(posedge mclk) din_pin <= ~din_pin;
		// With select held low the shift clock must idle low through the conversion.
		// Otherwise it stays high until the select rise is recognised, so that the
		// trailing fall cannot wake a port that has just powered down.
		if (hold)
			sclk_pin <= 1'h0;
		else
			cs_n_pin <= 1'h1;
		repeat (40) @(posedge mclk);
		sclk_pin <= 1'h0;
		while (conv_busy === 1'h1 && n < 400) begin
			@(posedge mclk);
			n++;
		end
	endtask
	task automatic blip;
		@(posedge mclk) cs_n_pin <= 1'h0;
		repeat (4) @(posedge mclk);
		cs_n_pin <= 1'h1;
	endtask
endmodule // adcp_host
`default_nettype wire

// file: adcp_monitor.sv
// Port checker for the converter serial port.
`timescale 1ns/1ps
`default_nettype none
module adcp_monitor (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       cs_n_pin,
	input wire logic       aclk_pin,
	input wire logic       dout_oe,
	input wire logic [2:0] mux_pos,
	input wire logic [2:0] mux_neg,
	input wire logic       neg_is_shared_ground,
	input wire logic       span_unipolar,
	input wire logic       conv_start,
	input wire logic       conv_busy,
	input wire logic       power_down
);
	logic [5:0] cs_run;
	logic [4:0] falls;
	logic       cs_d, a1, a2, a3;
	// ****
	// Cycles since the select pin moved, and conversion clock falls in a conversion.
	// ****
	always @(posedge mclk) begin
		{cs_d, a3, a2, a1} <= {cs_n_pin, a2, a1, aclk_pin};
		if (!rst_n) begin
			cs_run <= 6'h00;
			falls <= 5'h00;
		end else begin
			cs_run <= (cs_d != cs_n_pin) ? 6'h00 : cs_run + {5'h00, cs_run != 6'h3f};
			falls <= conv_start ? 5'h00 : falls + {4'h0, a3 && !a2 && conv_busy};
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	oe_idle_a: assert property (cs_n_pin && cs_run > 6'h28 |-> !dout_oe)
		else $error("output driven while deselected");
	glitch_hold_a: assert property ($rose(dout_oe) |-> !cs_n_pin && cs_run > 6'h07)
		else $error("select taken too early");
	start_quiet_a: assert property (conv_start |-> conv_busy && !dout_oe)
		else $error("start without busy");
	conv_len_a: assert property ($fell(conv_busy) |-> falls > 5'h0a && falls < 5'h0e)
		else $error("conversion length off");
	busy_quiet_a: assert property (conv_busy |-> !dout_oe)
		else $error("output driven in conversion");
	cfg_hold_a: assert property ($changed(mux_pos) || $changed(span_unipolar) |-> $past(conv_start))
		else $error("config moved outside start");
	pair_neg_a: assert property (!neg_is_shared_ground |-> mux_neg == (mux_pos ^ 3'h1))
		else $error("pair polarity wrong");
	sleep_idle_a: assert property (power_down |-> !conv_busy && !conv_start)
		else $error("conversion while asleep");
	cover property (conv_start);
	cover property ($rose(power_down));
	cover property ($rose(dout_oe));
	cover property (conv_busy && !cs_n_pin);
endmodule // adcp_monitor
bind adcp_port adcp_monitor u_mon (.mclk, .rst_n, .cs_n_pin, .aclk_pin, .dout_oe, .mux_pos,
	.mux_neg, .neg_is_shared_ground, .span_unipolar, .conv_start, .conv_busy, .power_down);
`default_nettype wire

// file: adcp_port.v
// Serial configuration port and control logic of an eight-input converter.
`timescale 1ns/1ps
`default_nettype none
`include "adcp_defs.vh"

module adcp_port (
	input  wire        mclk,
	input  wire        rst_n,
	input  wire        cs_n_pin,
	input  wire        sclk_pin,
	input  wire        din_pin,
	input  wire        aclk_pin,
	input  wire [11:0] adc_raw,
	output reg         dout,
	output reg         dout_oe,
	output reg  [2:0]  mux_pos,
	output reg  [2:0]  mux_neg,
	output reg         neg_is_shared_ground,
	output reg         span_unipolar,
	output reg         conv_start,
	output reg         conv_busy,
	output reg         power_down
);

	// ****************************************************************
	// State codes.
	// ****************************************************************
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_SHIFT = 3'h1;
	localparam [2:0] ST_CONV  = 3'h2;
	localparam [2:0] ST_DOWN  = 3'h3;
	localparam [2:0] ST_WAIT  = 3'h4;

	reg        cs_s1;
	reg        cs_s2;
	reg        sc_s1;
	reg        sc_s2;
	reg        sc_d;
	reg        dn_s1;
	reg        dn_s2;
	reg        ac_s1;
	reg        ac_s2;
	reg        ac_d;
	reg        cs_rec;
	reg        cs_rec_d;
	reg [1:0]  dg_cnt;
	reg [2:0]  state;
	reg [4:0]  bit_cnt;
	reg [3:0]  out_idx;
	reg [3:0]  conv_cnt;
	reg [7:0]  cfg;
	reg [7:0]  req_cfg;
	reg [11:0] result;
	reg        res_order;

	wire sclk_rise;
	wire sclk_fall;
	wire aclk_fall;
	wire cs_fall_rec;
	wire [4:0] cur_len;

	// ****************************************************************
	// Helper functions.
	// ****************************************************************
	function [4:0] word_len;
		input [1:0] wl;
		begin
			case (wl)
				`ADCP_WL_8:    word_len = `ADCP_LEN_8;
				`ADCP_WL_DOWN: word_len = `ADCP_LEN_10;
				`ADCP_WL_12:   word_len = `ADCP_LEN_12;
				default:       word_len = `ADCP_LEN_16;
			endcase
		end
	endfunction

	// Bits past the twelfth read as zero in either order.
	function out_bit;
		input [11:0] res;
		input        msb_first;
		input [3:0]  k;
		begin
			if (k >= `ADCP_RES_BITS)
				out_bit = 1'b0;
			else if (msb_first)
				out_bit = res[4'hb - k];
			else
				out_bit = res[k];
		end
	endfunction

	// ****************************************************************
	// Pin synchronisers and edge detection.
	// ****************************************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			sc_s1 <= 1'b0;
			sc_s2 <= 1'b0;
			sc_d  <= 1'b0;
			dn_s1 <= 1'b0;
			dn_s2 <= 1'b0;
			ac_s1 <= 1'b0;
			ac_s2 <= 1'b0;
			ac_d  <= 1'b0;
		end else begin
			cs_s1 <= cs_n_pin;
			cs_s2 <= cs_s1;
			sc_s1 <= sclk_pin;
			sc_s2 <= sc_s1;
			sc_d  <= sc_s2;
			dn_s1 <= din_pin;
			dn_s2 <= dn_s1;
			ac_s1 <= aclk_pin;
			ac_s2 <= ac_s1;
			ac_d  <= ac_s2;
		end
	end

	assign sclk_rise   = sc_s2 & ~sc_d;
	assign sclk_fall   = ~sc_s2 & sc_d;
	assign aclk_fall   = ~ac_s2 & ac_d;
	assign cs_fall_rec = ~cs_rec & cs_rec_d;
	assign cur_len     = word_len(cfg[`ADCP_F_WL_HI:`ADCP_F_WL_LO]);

	// ****************************************************************
	// Select deglitcher: a new level must hold over two falling edges.
	// ****************************************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			cs_rec   <= 1'b1;
			cs_rec_d <= 1'b1;
			dg_cnt   <= 2'h0;
		end else begin
			cs_rec_d <= cs_rec;
			if (cs_s2 == cs_rec) begin
				dg_cnt <= 2'h0;
			end else if (aclk_fall) begin
				if (dg_cnt == `ADCP_DEGLITCH_EDGES - 2'h1) begin
					cs_rec <= cs_s2;
					dg_cnt <= 2'h0;
				end else begin
					dg_cnt <= dg_cnt + 2'h1;
				end
			end
		end
	end

	// ****************************************************************
	// Exchange, conversion and power-down sequencing.
	// ****************************************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			state      <= ST_IDLE;
			bit_cnt    <= 5'h00;
			out_idx    <= 4'h0;
			conv_cnt   <= 4'h0;
			cfg        <= `ADCP_CFG_RST;
			req_cfg    <= `ADCP_CFG_RST;
			result     <= `ADCP_RESULT_RST;
			res_order  <= 1'b0;
			dout       <= 1'b0;
			dout_oe    <= 1'b0;
			conv_start <= 1'b0;
			conv_busy  <= 1'b0;
			power_down <= 1'b0;
		end else begin
			conv_start <= 1'b0;
			case (state)
				ST_IDLE: begin
					// A frame opens on recognised select low, also after a
					// conversion run with select held low.
					if (!cs_rec) begin
						state   <= ST_SHIFT;
						bit_cnt <= 5'h00;
						out_idx <= 4'h0;
						dout    <= out_bit(result, res_order, 4'h0);
						dout_oe <= 1'b1;
					end
				end
				ST_SHIFT: begin
					if (cs_rec) begin
						state   <= ST_IDLE;
						dout_oe <= 1'b0;
					end else if (bit_cnt >= `ADCP_LEN_8 && bit_cnt == cur_len) begin
						dout_oe <= 1'b0;
						if (cfg[`ADCP_F_WL_HI:`ADCP_F_WL_LO] == `ADCP_WL_DOWN) begin
							state      <= ST_DOWN;
							power_down <= 1'b1;
						end else begin
							state      <= ST_CONV;
							req_cfg    <= cfg;
							conv_cnt   <= 4'h0;
							conv_start <= 1'b1;
							conv_busy  <= 1'b1;
						end
					end else begin
						if (sclk_rise) begin
							if (bit_cnt < `ADCP_LEN_8)
								cfg <= {cfg[6:0], dn_s2};
							bit_cnt <= bit_cnt + 5'h01;
						end
						if (sclk_fall && bit_cnt != 5'h00) begin
							out_idx <= out_idx + 4'h1;
							dout    <= out_bit(result, res_order, out_idx + 4'h1);
						end
					end
				end
				ST_CONV: begin
					// Shift clock and select are not watched until done.
					if (aclk_fall) begin
						if (conv_cnt == `ADCP_CONV_EDGES - 4'h1) begin
							conv_busy <= 1'b0;
							res_order <= req_cfg[`ADCP_F_ORDER];
							if (req_cfg[`ADCP_F_SPAN])
								result <= adc_raw;
							else
								result <= adc_raw ^ `ADCP_BIPOLAR_FLIP;
							state <= cs_rec ? ST_IDLE : ST_WAIT;
						end else begin
							conv_cnt <= conv_cnt + 4'h1;
						end
					end
				end
				ST_WAIT: begin
					// Select held low through the conversion: one idle cycle
					// lets the new result settle before the next frame.
					state <= ST_IDLE;
				end
				ST_DOWN: begin
					if (cs_fall_rec || (!cs_rec && (sclk_rise || sclk_fall))) begin
						power_down <= 1'b0;
						state      <= ST_IDLE;
					end
				end
				default: begin
					state   <= ST_IDLE;
					dout_oe <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************************************
	// Multiplexer and span controls for the running conversion.
	// ****************************************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			mux_pos              <= 3'h0;
			mux_neg              <= 3'h1;
			neg_is_shared_ground <= 1'b0;
			span_unipolar        <= 1'b0;
		end else if (conv_start) begin
			mux_pos <= {req_cfg[`ADCP_F_SEL_HI:`ADCP_F_SEL_LO], req_cfg[`ADCP_F_ODD]};
			mux_neg <= {req_cfg[`ADCP_F_SEL_HI:`ADCP_F_SEL_LO], ~req_cfg[`ADCP_F_ODD]};
			neg_is_shared_ground <= req_cfg[`ADCP_F_SINGLE];
			span_unipolar        <= req_cfg[`ADCP_F_SPAN];
		end
	end

endmodule // adcp_port

`default_nettype wire

// file: adcp_testbench.sv
// Self-checking bench for the converter serial port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        mclk = 1'h0;
	logic        rst_n = 1'h0;
	logic        aclk_pin = 1'h0;
	logic [3:0]  ac = 4'h0;
	logic [11:0] adc_raw = 12'h000;
	int          num_errors = 0;
	int          num_checks = 0;
	wire         cs_n_pin, sclk_pin, din_pin, dout, dout_oe, conv_start, conv_busy;
	wire         power_down, neg_is_shared_ground, span_unipolar;
	wire [2:0]   mux_pos, mux_neg;
	logic [7:0]  cfg_t [8] = '{8'h0e, 8'h5b, 8'ha4, 8'hf2, 8'h3f, 8'h66, 8'hcc, 8'h9e};
	logic [11:0] raw_t [8] = '{12'hffe, 12'hfff, 12'h800, 12'h7ff, 12'h000, 12'h000, 12'ha5c, 12'h123};
	logic [2:0]  pos_t [8] = '{3'h0, 3'h3, 3'h4, 3'h7, 3'h6, 3'h5, 3'h1, 3'h2};
	logic        gnd_t [8] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1};
	logic        hold_t [8] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0};
	logic [4:0]  lens [4] = '{5'h08, 5'h0a, 5'h0c, 5'h10};
	adcp_port u_adcp_port (.mclk, .rst_n, .cs_n_pin, .sclk_pin, .din_pin, .aclk_pin, .adc_raw,
		.dout, .dout_oe, .mux_pos, .mux_neg, .neg_is_shared_ground, .span_unipolar,
		.conv_start, .conv_busy, .power_down);
	adcp_host u_adcp_host (.mclk, .dout, .dout_oe, .conv_busy, .cs_n_pin, .sclk_pin, .din_pin);
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		ac <= (ac == 4'h4) ? 4'h0 : ac + 4'h1;
		if (ac == 4'h4) aclk_pin <= ~aclk_pin;
	end
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		chk_word({15'h0000, got}, {15'h0000, exp}, what);
	endtask
	function automatic logic [15:0] want(input logic [11:0] r, input logic m, input logic [4:0] n);
		want = 16'h0000;
		for (int k = 0; k < 12; k++)
			if (k < n) want[k] = m ? r[11 - k] : r[k];
	endfunction
	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ****
	// Table of exchanges, then sleep, wake, a short select pulse and a second reset.
	// ****
	initial begin
		logic [15:0] got;
		logic [11:0] res;
		logic        msb;
		logic        seen;
		res = 12'h000;
		msb = 1'h0;
		seen = 1'h0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'h1;
		@(posedge mclk);
		chk_bit(dout_oe, 1'h0, "oe after reset");
		for (int r = 0; r < 8; r++) begin
			@(posedge mclk) adc_raw <= raw_t[r];
			u_adcp_host.xfer(cfg_t[r], got, hold_t[r]);
			chk_bit(conv_busy, 1'h0, "busy");
			chk_word(got, want(res, msb, lens[cfg_t[r][1:0]]), "result");
			chk_word({13'h0000, mux_pos}, {13'h0000, pos_t[r]}, "input");
			chk_bit(neg_is_shared_ground, gnd_t[r], "ground");
			chk_bit(span_unipolar, cfg_t[r][3], "span");
			res = cfg_t[r][3] ? raw_t[r] : raw_t[r] ^ 12'h800;
			msb = cfg_t[r][2];
		end
		u_adcp_host.xfer(8'h01, got, 1'h0);
		chk_word(got, want(res, msb, 5'h0a), "sleep word");
		chk_bit(power_down, 1'h1, "asleep");
		u_adcp_host.xfer(8'h0e, got, 1'h0);
		chk_bit(power_down, 1'h0, "awake");
		chk_word(got, want(res, msb, 5'h0c), "wake word");
		chk_bit(conv_busy, 1'h0, "busy after wake");
		u_adcp_host.blip();
		repeat (40) begin
			@(posedge mclk);
			seen = seen | dout_oe;
		end
		chk_bit(seen, 1'h0, "pulse");
		rst_n <= 1'h0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'h1;
		@(negedge mclk);
		chk_bit(dout_oe, 1'h0, "oe after second reset");
		chk_bit(power_down, 1'h0, "awake after second reset");
		u_adcp_host.xfer(8'h0e, got, 1'h0);
		chk_word(got, want(12'h000, 1'h0, 5'h0c), "result after reset");
		conclude();
	end
	initial begin
		#1000000;
		num_errors++;
		conclude();
	end
endmodule // testbench
`default_nettype wire
